// File: inc/spfmu_pkg.sv
package spfmu_pkg;

   // ********************************
   // Register byte offsets
   // ********************************
   localparam logic [7:0] OFF_SERIAL_CONTROL = 8'h00;
   localparam logic [7:0] OFF_SERIAL_BUFFER = 8'h04;
   localparam logic [7:0] OFF_POWER_CONTROL = 8'h08;
   localparam logic [7:0] OFF_SLAVE_ADDRESS = 8'h0c;
   localparam logic [7:0] OFF_SLAVE_MASK = 8'h10;

   // ********************************
   // Field positions
   // ********************************
   localparam int CTL_MODE_OR_ERROR = 7;
   localparam int CTL_MODE_HIGH = 6;
   localparam int CTL_ADDR_FILTER = 5;
   localparam int CTL_RX_ENABLE = 4;
   localparam int CTL_TX_NINTH = 3;
   localparam int CTL_RX_NINTH = 2;
   localparam int CTL_TX_DONE = 1;
   localparam int CTL_RX_DONE = 0;
   localparam int PWR_BAUD_DOUBLER = 7;
   localparam int PWR_ERROR_VIEW = 6;

   // ********************************
   // Reset values
   // ********************************
   localparam logic [7:0] ADDR_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // ********************************
   // Counts of cycles, slices and bits, and the word transfer size code
   // ********************************
   localparam logic [3:0] SHIFT_PERIOD_SLOW = 4'hc;
   localparam logic [3:0] SHIFT_PERIOD_FAST = 4'h4;
   localparam logic [3:0] SYNC_BITS = 4'h8;
   localparam logic [3:0] FRAME_BITS_10 = 4'ha;
   localparam logic [3:0] FRAME_BITS_11 = 4'hb;
   localparam logic [3:0] SLICE_LAST = 4'hf;
   localparam logic [3:0] SLICE_VOTE_A = 4'h7;
   localparam logic [3:0] SLICE_VOTE_B = 4'h8;
   localparam logic [3:0] SLICE_VOTE_C = 4'h9;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic {RX_HUNT, RX_FRAME} spfmu_rx_state_t;

endpackage

// File: logic/spfmu_top.sv
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
// Operation
// - Mode 0: transmit done set after last bit
// - Mode 0 receive: drive clock, sample rising
// - Mode 0: receive done after last rise, halts
// - Mode 1: start, 8 data LSB first, stop
// - Mode 1 rate: overflow over 16 or 32
// - Buffer write starts; bits on counter rollovers
// - Transmit done at 10th/11th rollover
// - Watch input at 16x; falling edge resets counter
// - Vote two of three at states 7,8,9
// - Start bit not zero aborts reception
// - Load only if done clear; stop valid needed only with filter on
// - Mode 2: eleven bits with programmable ninth
// - Mode 2 rate: clock over 32 or 64
// - Mode 3 like mode 2, timer rate
// - Mode bits select modes 0 to 3
// - Reception start conditions per mode
// - Framing error sticky until software clears
// - Control bit 7 shows error or mode bit
// - Modes 2/3 filter: ninth high, address match
// - Mode 1 filter: valid frame, address match
// - Given address uses masked slave address bits
// - Broadcast is address OR mask
// - Address and mask reset to zero
// - Mode 0 shift rate: clock/12 or clock/4
// - Buffer write transmits, read gives receive
module spfmu_top (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // Baud source
   input wire logic i_timer_ovf,
   // Serial pins
   input wire logic i_rxd,
   output logic o_rxd,
   output logic o_rxd_oe_n,
   output logic o_txd,
   // Event
   output logic o_serial_event
);

   // ********************************
   // Storage
   // ********************************
   logic frame_mode_low_bit_reg, frame_mode_high_bit_reg, address_filter_enable_reg;
   logic rx_enable_reg, transmit_ninth_bit_reg, received_ninth_bit_reg;
   logic transmit_done_flag_reg, receive_done_flag_reg, framing_error_flag_reg;
   logic baud_doubler_select_reg, error_view_select_reg;
   logic [7:0] slave_address_reg, slave_address_mask_reg, rx_buffer_reg;
   logic dph_wr_reg;
   logic [7:0] dph_addr_reg;
   logic [1:0] rxd_sync_reg;
   logic [1:0] presc_reg;
   logic ovf_half_reg;
   logic [3:0] tx_div_reg, tx_cnt_reg, shift_ph_reg;
   logic [10:0] tx_shift_reg;
   logic tx_busy_reg, sync_rx_busy_reg;
   spfmu_pkg::spfmu_rx_state_t rx_state_reg;
   logic [3:0] rx_div_reg, rx_cnt_reg;
   logic [8:0] rx_shift_reg;
   logic [1:0] vote_reg;
   logic rx_last_reg;

   // ********************************
   // Mode and rate decode
   // ********************************
   wire rxd_s = rxd_sync_reg[1];
   wire [1:0] mode = {frame_mode_high_bit_reg, frame_mode_low_bit_reg};
   wire mode0 = (mode == 2'h0);
   wire mode1 = (mode == 2'h1);
   wire mode2 = (mode == 2'h2);
   // Mode 2 takes 16 slices from the core clock, modes 1 and 3 from the timer
   wire tick_core = baud_doubler_select_reg ? presc_reg[0] : (&presc_reg);
   wire tick_timer = i_timer_ovf & (baud_doubler_select_reg | ovf_half_reg);
   wire tick16 = mode2 ? tick_core : tick_timer;
   wire [3:0] frame_len = mode1 ? spfmu_pkg::FRAME_BITS_10 : spfmu_pkg::FRAME_BITS_11;
   wire rollover = tick16 & (tx_div_reg == spfmu_pkg::SLICE_LAST);
   wire [3:0] sh_period = address_filter_enable_reg ? spfmu_pkg::SHIFT_PERIOD_FAST
                                                    : spfmu_pkg::SHIFT_PERIOD_SLOW;
   wire [3:0] sh_fall = {2'b00, sh_period[3:2]};
   wire [3:0] sh_rise = sh_period - sh_fall;
   wire sh_end = (shift_ph_reg == sh_period - 4'h1);
   wire sh_active = mode0 & (tx_busy_reg | sync_rx_busy_reg);

   // ********************************
   // Bus decode
   // ********************************
   wire addr_ph = i_hsel & i_htrans[1] & i_hready;
   wire wr_ctl = dph_wr_reg & (dph_addr_reg == spfmu_pkg::OFF_SERIAL_CONTROL);
   wire wr_buf = dph_wr_reg & (dph_addr_reg == spfmu_pkg::OFF_SERIAL_BUFFER);
   wire wr_pwr = dph_wr_reg & (dph_addr_reg == spfmu_pkg::OFF_POWER_CONTROL);
   wire wr_sad = dph_wr_reg & (dph_addr_reg == spfmu_pkg::OFF_SLAVE_ADDRESS);
   wire wr_msk = dph_wr_reg & (dph_addr_reg == spfmu_pkg::OFF_SLAVE_MASK);
   wire [7:0] wd = i_hwdata[7:0];

   // ********************************
   // Transmit start and completion
   // ********************************
   // Writes landing while a transfer is running are dropped
   wire tx_start = wr_buf & ~tx_busy_reg & ~(mode0 & sync_rx_busy_reg);
   wire tx_done_sync = mode0 & tx_busy_reg & sh_end & (tx_cnt_reg == spfmu_pkg::SYNC_BITS - 4'h1);
   wire tx_done_async = ~mode0 & tx_busy_reg & rollover & (tx_cnt_reg == frame_len - 4'h1);
   wire tx_done_set = tx_done_sync | tx_done_async;

   // ********************************
   // Synchronous receive
   // ********************************
   wire sync_rx_start = mode0 & rx_enable_reg & ~receive_done_flag_reg & ~tx_busy_reg
                        & ~sync_rx_busy_reg & ~tx_start;
   wire sync_rise = sh_active & sync_rx_busy_reg & (shift_ph_reg == sh_rise);
   wire sync_rx_last = sync_rise & (rx_cnt_reg == spfmu_pkg::SYNC_BITS - 4'h1);
   wire vote_bit_or_pin;
   wire [8:0] rx_shift_in = {vote_bit_or_pin, rx_shift_reg[8:1]};

   // ********************************
   // Asynchronous receive
   // ********************************
   wire vote_bit = (vote_reg[0] & vote_reg[1]) | (vote_reg[0] & rxd_s) | (vote_reg[1] & rxd_s);
   assign vote_bit_or_pin = mode0 ? rxd_s : vote_bit;
   wire rx_edge = (rx_state_reg == spfmu_pkg::RX_HUNT) & ~mode0 & rx_enable_reg
                  & rx_last_reg & ~rxd_s;
   wire rx_decide = (rx_state_reg == spfmu_pkg::RX_FRAME) & (rx_div_reg == spfmu_pkg::SLICE_VOTE_C);
   wire rx_bad_start = rx_decide & (rx_cnt_reg == 4'h0) & vote_bit;
   wire rx_at_stop = rx_decide & (rx_cnt_reg == frame_len - 4'h1);
   wire [7:0] rx_byte = mode1 ? rx_shift_reg[8:1] : rx_shift_reg[7:0];
   wire rx_ninth = mode1 ? vote_bit : rx_shift_reg[8];
   wire [7:0] bcast = slave_address_reg | slave_address_mask_reg;
   wire given_hit = ((rx_byte ^ slave_address_reg) & slave_address_mask_reg) == 8'h00;
   wire bcast_hit = (rx_byte & bcast) == bcast;
   wire filter_ok = mode1 ? (vote_bit & (given_hit | bcast_hit))
                          : (rx_ninth & vote_bit & (given_hit | bcast_hit));
   wire rx_load = rx_at_stop & tick16 & ~receive_done_flag_reg
                  & (~address_filter_enable_reg | filter_ok);
   wire sync_load = sync_rx_last;
   wire fe_set = rx_at_stop & tick16 & ~vote_bit;

   // ********************************
   // Register next values
   // ********************************
   // Hardware set wins over a software clear landing in the same cycle
   wire ctl_err_view = error_view_select_reg;
   wire mode_low_next = (wr_ctl & ~ctl_err_view) ? wd[spfmu_pkg::CTL_MODE_OR_ERROR]
                                                 : frame_mode_low_bit_reg;
   wire fe_next = fe_set | ((wr_ctl & ctl_err_view) ? wd[spfmu_pkg::CTL_MODE_OR_ERROR]
                                                    : framing_error_flag_reg);
   wire mode_high_next = wr_ctl ? wd[spfmu_pkg::CTL_MODE_HIGH] : frame_mode_high_bit_reg;
   wire filt_next = wr_ctl ? wd[spfmu_pkg::CTL_ADDR_FILTER] : address_filter_enable_reg;
   wire ren_next = wr_ctl ? wd[spfmu_pkg::CTL_RX_ENABLE] : rx_enable_reg;
   wire tn_next = wr_ctl ? wd[spfmu_pkg::CTL_TX_NINTH] : transmit_ninth_bit_reg;
   wire rn_next = (rx_load & ~mode0) ? rx_ninth
                  : (wr_ctl ? wd[spfmu_pkg::CTL_RX_NINTH] : received_ninth_bit_reg);
   wire td_next = tx_done_set | (wr_ctl ? wd[spfmu_pkg::CTL_TX_DONE] : transmit_done_flag_reg);
   wire rd_next = rx_load | sync_load
                  | (wr_ctl ? wd[spfmu_pkg::CTL_RX_DONE] : receive_done_flag_reg);
   wire dbl_next = wr_pwr ? wd[spfmu_pkg::PWR_BAUD_DOUBLER] : baud_doubler_select_reg;
   wire evs_next = wr_pwr ? wd[spfmu_pkg::PWR_ERROR_VIEW] : error_view_select_reg;
   wire [7:0] sad_next = wr_sad ? wd : slave_address_reg;
   wire [7:0] msk_next = wr_msk ? wd : slave_address_mask_reg;
   wire [7:0] rxbuf_next = sync_load ? rx_shift_in[8:1] : (rx_load ? rx_byte : rx_buffer_reg);

   // ********************************
   // Read mux, from next values so a read right after a write sees it
   // ********************************
   wire [7:0] ctl_view = {evs_next ? fe_next : mode_low_next, mode_high_next, filt_next, ren_next,
                          tn_next, rn_next, td_next, rd_next};
   wire [7:0] ra = i_haddr[7:0];
   wire [7:0] rd_byte = (ra == spfmu_pkg::OFF_SERIAL_CONTROL) ? ctl_view
                      : (ra == spfmu_pkg::OFF_SERIAL_BUFFER) ? rxbuf_next
                      : (ra == spfmu_pkg::OFF_POWER_CONTROL) ? {dbl_next, evs_next, 6'h00}
                      : (ra == spfmu_pkg::OFF_SLAVE_ADDRESS) ? sad_next
                      : (ra == spfmu_pkg::OFF_SLAVE_MASK) ? msk_next : 8'h00;

   // ********************************
   // Bus slave
   // ********************************
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         dph_wr_reg <= 1'b0;
         dph_addr_reg <= 8'h00;
         o_hrdata <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end else begin
         dph_wr_reg <= addr_ph & i_hwrite & (i_hsize == spfmu_pkg::HSIZE_WORD);
         dph_addr_reg <= ra;
         if (addr_ph & ~i_hwrite) begin
            o_hrdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   // ********************************
   // Control registers
   // ********************************
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         frame_mode_low_bit_reg <= 1'b0;
         frame_mode_high_bit_reg <= 1'b0;
         address_filter_enable_reg <= 1'b0;
         rx_enable_reg <= 1'b0;
         transmit_ninth_bit_reg <= 1'b0;
         received_ninth_bit_reg <= 1'b0;
         transmit_done_flag_reg <= 1'b0;
         receive_done_flag_reg <= 1'b0;
         framing_error_flag_reg <= 1'b0;
         baud_doubler_select_reg <= 1'b0;
         error_view_select_reg <= 1'b0;
         slave_address_reg <= spfmu_pkg::ADDR_RESET;
         slave_address_mask_reg <= spfmu_pkg::ADDR_RESET;
         rx_buffer_reg <= spfmu_pkg::BYTE_RESET;
         o_serial_event <= 1'b0;
      end else begin
         frame_mode_low_bit_reg <= mode_low_next;
         frame_mode_high_bit_reg <= mode_high_next;
         address_filter_enable_reg <= filt_next;
         rx_enable_reg <= ren_next;
         transmit_ninth_bit_reg <= tn_next;
         received_ninth_bit_reg <= rn_next;
         transmit_done_flag_reg <= td_next;
         receive_done_flag_reg <= rd_next;
         framing_error_flag_reg <= fe_next;
         baud_doubler_select_reg <= dbl_next;
         error_view_select_reg <= evs_next;
         slave_address_reg <= sad_next;
         slave_address_mask_reg <= msk_next;
         rx_buffer_reg <= rxbuf_next;
         o_serial_event <= transmit_done_flag_reg | receive_done_flag_reg;
      end
   end

   // ********************************
   // Rate generation and input synchroniser
   // ********************************
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rxd_sync_reg <= 2'b11;
         presc_reg <= 2'h0;
         ovf_half_reg <= 1'b0;
         tx_div_reg <= 4'h0;
         shift_ph_reg <= 4'h0;
      end else begin
         rxd_sync_reg <= {rxd_sync_reg[0], i_rxd};
         presc_reg <= presc_reg + 2'h1;
         ovf_half_reg <= ovf_half_reg ^ i_timer_ovf;
         if (tick16) begin
            tx_div_reg <= tx_div_reg + 4'h1;
         end
         shift_ph_reg <= (~sh_active | sh_end) ? 4'h0 : shift_ph_reg + 4'h1;
      end
   end

   // ********************************
   // Transmitter and shift clock
   // ********************************
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tx_busy_reg <= 1'b0;
         tx_cnt_reg <= 4'h0;
         tx_shift_reg <= 11'h7ff;
         o_txd <= 1'b1;
         o_rxd <= 1'b1;
         o_rxd_oe_n <= 1'b1;
      end else if (tx_start) begin
         tx_busy_reg <= 1'b1;
         tx_cnt_reg <= 4'h0;
         tx_shift_reg <= mode0 ? {3'b111, wd} : {1'b1, transmit_ninth_bit_reg | mode1, wd, 1'b0};
      end else if (mode0) begin
         o_rxd_oe_n <= ~tx_busy_reg;
         if (sh_active & (shift_ph_reg == 4'h0) & tx_busy_reg) begin
            o_rxd <= tx_shift_reg[0];
         end
         if (sh_active & (shift_ph_reg == sh_fall)) begin
            o_txd <= 1'b0;
         end else if (sh_active & (shift_ph_reg == sh_rise)) begin
            o_txd <= 1'b1;
         end
         if (tx_busy_reg & sh_end) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            tx_busy_reg <= ~tx_done_sync;
         end
      end else begin
         o_rxd_oe_n <= 1'b1;
         o_rxd <= 1'b1;
         if (tx_busy_reg & rollover) begin
            o_txd <= tx_shift_reg[0];
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            tx_busy_reg <= ~tx_done_async;
         end else if (!tx_busy_reg) begin
            o_txd <= 1'b1;
         end
      end
   end

   // ********************************
   // Receiver
   // ********************************
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rx_state_reg <= spfmu_pkg::RX_HUNT;
         sync_rx_busy_reg <= 1'b0;
         rx_div_reg <= 4'h0;
         rx_cnt_reg <= 4'h0;
         rx_shift_reg <= 9'h000;
         vote_reg <= 2'b11;
         rx_last_reg <= 1'b1;
      end else if (mode0) begin
         rx_state_reg <= spfmu_pkg::RX_HUNT;
         if (sync_rx_start) begin
            sync_rx_busy_reg <= 1'b1;
            rx_cnt_reg <= 4'h0;
         end else if (sync_rise) begin
            rx_shift_reg <= rx_shift_in;
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            sync_rx_busy_reg <= ~sync_rx_last;
         end
      end else if (tick16) begin
         sync_rx_busy_reg <= 1'b0;
         rx_last_reg <= rxd_s;
         unique case (rx_state_reg)
            spfmu_pkg::RX_HUNT: begin
               if (rx_edge) begin
                  rx_state_reg <= spfmu_pkg::RX_FRAME;
                  rx_div_reg <= 4'h0;
                  rx_cnt_reg <= 4'h0;
               end
            end
            spfmu_pkg::RX_FRAME: begin
               rx_div_reg <= rx_div_reg + 4'h1;
               if (rx_div_reg == spfmu_pkg::SLICE_VOTE_A) begin
                  vote_reg[0] <= rxd_s;
               end
               if (rx_div_reg == spfmu_pkg::SLICE_VOTE_B) begin
                  vote_reg[1] <= rxd_s;
               end
               if (rx_bad_start | rx_at_stop) begin
                  rx_state_reg <= spfmu_pkg::RX_HUNT;
               end else if (rx_decide) begin
                  rx_cnt_reg <= rx_cnt_reg + 4'h1;
                  if (rx_cnt_reg != 4'h0) begin
                     rx_shift_reg <= rx_shift_in;
                  end
               end
            end
         endcase
      end
   end

endmodule

// File: verif/spfmu_chk.sv
`timescale 1ns/1ps
module spfmu_chk (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   // Register bus
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] o_hrdata,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   // Serial pins and event
   input wire logic o_rxd,
   input wire logic o_rxd_oe_n,
   input wire logic o_txd,
   input wire logic o_serial_event
);
   // ********************************
   // Bus decode and age counters
   // ********************************
   logic addr_ph, rd_reg, unm_reg, ctl_wr_reg, buf_wr_reg;
   logic [3:0] ctl_age_reg, buf_age_reg;
   logic [7:0] low_reg;
   assign addr_ph = i_hsel & i_htrans[1] & o_hreadyout;
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_reg <= 1'b0;
         unm_reg <= 1'b0;
         ctl_wr_reg <= 1'b0;
         buf_wr_reg <= 1'b0;
         ctl_age_reg <= 4'hf;
         buf_age_reg <= 4'hf;
         low_reg <= 8'h00;
      end else begin
         rd_reg <= addr_ph & !i_hwrite;
         unm_reg <= addr_ph & !i_hwrite & ((i_haddr[1:0] != 2'h0) | (i_haddr[7:0] > spfmu_pkg::OFF_SLAVE_MASK));
         ctl_wr_reg <= addr_ph & i_hwrite & (i_haddr[7:0] == spfmu_pkg::OFF_SERIAL_CONTROL);
         buf_wr_reg <= addr_ph & i_hwrite & (i_haddr[7:0] == spfmu_pkg::OFF_SERIAL_BUFFER);
         // Ages saturate so a long quiet spell never wraps into a false match
         ctl_age_reg <= ctl_wr_reg ? 4'h0 : ctl_age_reg + {3'h0, ctl_age_reg != 4'hf};
         buf_age_reg <= buf_wr_reg ? 4'h0 : buf_age_reg + {3'h0, buf_age_reg != 4'hf};
         low_reg <= o_txd ? 8'h00 : low_reg + {7'h0, low_reg != 8'hff};
      end
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   property p_ready; o_hreadyout; endproperty
   a_ready: assert property (p_ready) else $error("hreadyout low");
   property p_okay; !o_hresp; endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_unmapped; unm_reg |-> o_hrdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_rd_stands; !rd_reg |-> $stable(o_hrdata); endproperty
   a_rd_stands: assert property (p_rd_stands) else $error("read data moved without a read");
   property p_ev_fall; $fell(o_serial_event) |-> ctl_age_reg <= 4'h4; endproperty
   a_ev_fall: assert property (p_ev_fall) else $error("event dropped without a control write");
   // Shift clock lows are 2 or 6 clocks; async bits are never shorter than 32
   property p_clk_low; $rose(o_txd) |-> (low_reg == 8'h02) || (low_reg == 8'h06) || (low_reg >= 8'h20); endproperty
   a_clk_low: assert property (p_clk_low) else $error("low time on serial out illegal");
   property p_data_hi; !o_rxd_oe_n && $changed(o_rxd) |-> o_txd; endproperty
   a_data_hi: assert property (p_data_hi) else $error("data moved while shift clock low");
   property p_oe_start; $fell(o_rxd_oe_n) |-> buf_age_reg <= 4'he; endproperty
   a_oe_start: assert property (p_oe_start) else $error("data pin driven without buffer write");
endmodule

bind spfmu_top spfmu_chk u_chk (.i_ref_clk, .i_resetn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .o_hrdata,
   .o_hreadyout, .o_hresp, .o_rxd, .o_rxd_oe_n, .o_txd, .o_serial_event);

// File: verif/spfmu_far_node.sv
`timescale 1ns/1ps
module spfmu_far_node (
   // Clock and line
   input wire logic i_clk,
   input wire logic i_line_in,
   input wire logic i_pin_in,
   // Shift register side
   input wire logic i_sync_en,
   input wire logic [7:0] i_sync_byte,
   output logic o_line_out,
   output logic [7:0] o_cap
);
   int idx = 0;
   initial begin
      o_line_out = 1'b1;
      o_cap = 8'h00;
   end
   // Next bit only after the falling shift edge, so it is stable across the rise
   always @(negedge i_line_in) begin
      if (i_sync_en) begin
         o_line_out <= i_sync_byte[idx];
         idx <= (idx + 1) % 8;
      end
   end
   always @(posedge i_line_in) begin
      if (i_sync_en) begin
         o_cap <= {i_pin_in, o_cap[7:1]};
      end
   end
   // Remote node: line returns to the idle mark level after the frame
   task automatic send(input logic [10:0] bits, input int nbits, input int bit_clks);
      for (int i = 0; i < nbits; i++) begin
         o_line_out <= bits[i];
         repeat (bit_clks) @(posedge i_clk);
      end
      o_line_out <= 1'b1;
   endtask
   task automatic grab(input int nbits, input int bit_clks, output logic [10:0] bits);
      int n;
      n = 0;
      bits = 'x;
      while (i_line_in !== 1'b0 && n < 4000) begin
         @(posedge i_clk);
         n++;
      end
      if (n < 4000) begin
         bits = '1;
         repeat (bit_clks / 2) @(posedge i_clk);
         for (int i = 0; i < nbits; i++) begin
            bits[i] = i_line_in;
            repeat (bit_clks) @(posedge i_clk);
         end
      end
   endtask
endmodule

// File: verif/spfmu_bench.sv
`timescale 1ns/1ps
module spfmu_bench;
   // ********************************
   // Stimulus, wiring and helpers
   // ********************************
   logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0, i_timer_ovf = 1'b0, sync_en = 1'b0;
   logic [1:0] i_htrans = 2'h0, ovf_cnt = 2'h0;
   logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata;
   logic o_hreadyout, o_hresp, o_rxd, o_rxd_oe_n, o_txd, o_serial_event, far_out, rx_pin;
   logic [7:0] cap, q;
   logic [10:0] fr;
   int fails = 0, num_checks = 0, rises = 0;
   // Rows: write flag, address, write data, expected read
   logic [27:0] rows [15] = '{28'h0_00_00_00, 28'h0_04_00_00, 28'h0_08_00_00, 28'h0_0c_00_00, 28'h0_10_00_00,
      28'h1_0c_a4_00, 28'h0_0c_00_a4, 28'h1_10_fa_00, 28'h0_10_00_fa, 28'h1_14_55_00, 28'h0_14_00_00,
      28'h1_08_80_00, 28'h0_08_00_80, 28'h1_00_80_00, 28'h0_00_00_80};
   always #12.5 i_ref_clk = ~i_ref_clk;
   // Shift clock rises, so a receive that restarts on its own is caught
   always @(posedge o_txd) rises <= rises + 1;
   // Overflow every third clock gives a 48-clock bit with the doubler set
   always @(posedge i_ref_clk) begin
      ovf_cnt <= (ovf_cnt == 2'h2) ? 2'h0 : ovf_cnt + 2'h1;
      i_timer_ovf <= (ovf_cnt == 2'h2);
   end
   assign rx_pin = (o_rxd_oe_n === 1'b0) ? o_rxd : far_out;
   spfmu_top uut (.i_ref_clk, .i_resetn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'h2), .i_hwdata,
      .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_timer_ovf, .i_rxd(rx_pin), .o_rxd,
      .o_rxd_oe_n, .o_txd, .o_serial_event);
   spfmu_far_node far (.i_clk(i_ref_clk), .i_line_in(o_txd), .i_pin_in(rx_pin), .i_sync_en(sync_en),
      .i_sync_byte(8'hc3), .o_line_out(far_out), .o_cap(cap));
   task automatic cmp(input string nm, input logic [10:0] e, input logic [10:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wait_hi(input logic ev, input int lim);
      int n;
      n = 0;
      while ((ev ? o_serial_event : o_hreadyout) !== 1'b1 && n < lim) begin
         @(posedge i_ref_clk);
         n++;
      end
      if (n >= lim) begin
         fails++;
         test_done();
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      i_hsel <= 1'b1;
      i_htrans <= 2'h2;
      i_hwrite <= wr;
      i_haddr <= {24'h0, a};
      @(posedge i_ref_clk);
      wait_hi(1'b0, 20);
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= {24'h0, d};
      @(posedge i_ref_clk);
      wait_hi(1'b0, 20);
      q = o_hrdata[7:0];
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      cmp(nm, {3'h0, e}, {3'h0, q});
   endtask
   initial begin
      repeat (5) @(posedge i_ref_clk);
      cmp("reset pins", 11'h00d, {7'h0, o_txd, o_rxd_oe_n, o_serial_event, o_hreadyout});
      i_resetn <= 1'b1;
      @(posedge i_ref_clk);
      for (int i = 0; i < 15; i++) begin
         bus(rows[i][24], rows[i][23:16], rows[i][15:8]);
         if (!rows[i][24]) begin
            cmp("register", {3'h0, rows[i][7:0]}, {3'h0, q});
         end
      end
      bus(1'b1, 8'h04, 8'h5a);
      far.grab(10, 48, fr);
      cmp("mode1 frame", {2'b11, 8'h5a, 1'b0}, fr);
      wait_hi(1'b1, 400);
      rdc("mode1 done", 8'h00, 8'h82);
      bus(1'b1, 8'h00, 8'h90);
      far.send({2'b11, 8'h3c, 1'b0}, 10, 48);
      wait_hi(1'b1, 400);
      rdc("mode1 rx", 8'h04, 8'h3c);
      rdc("mode1 stop", 8'h00, 8'h95);
      bus(1'b1, 8'h00, 8'h50);
      far.send({2'b10, 8'h3c, 1'b0}, 11, 32);
      wait_hi(1'b1, 400);
      rdc("mode2 rx", 8'h00, 8'h51);
      far.send({2'b01, 8'hc5, 1'b0}, 11, 32);
      rdc("kept while done", 8'h04, 8'h3c);
      bus(1'b1, 8'h08, 8'hc0);
      rdc("error view", 8'h00, 8'hd1);
      bus(1'b1, 8'h08, 8'h80);
      rdc("mode view", 8'h00, 8'h51);
      bus(1'b1, 8'h00, 8'h50);
      far.send(11'h000, 1, 4);
      repeat (40) @(posedge i_ref_clk);
      far.send({2'b11, 8'h69, 1'b0}, 11, 32);
      wait_hi(1'b1, 400);
      rdc("after glitch", 8'h04, 8'h69);
      bus(1'b1, 8'h08, 8'hc0);
      rdc("error sticky", 8'h00, 8'hd5);
      bus(1'b1, 8'h00, 8'h50);
      bus(1'b1, 8'h08, 8'h80);
      bus(1'b1, 8'h00, 8'h70);
      far.send({2'b11, 8'hb0, 1'b0}, 11, 32);
      far.send({2'b10, 8'ha1, 1'b0}, 11, 32);
      repeat (20) @(posedge i_ref_clk);
      cmp("filtered", 11'h000, {10'h0, o_serial_event});
      far.send({2'b11, 8'ha1, 1'b0}, 11, 32);
      wait_hi(1'b1, 400);
      rdc("given address", 8'h04, 8'ha1);
      bus(1'b1, 8'h00, 8'h70);
      far.send({2'b11, 8'hfe, 1'b0}, 11, 32);
      wait_hi(1'b1, 400);
      rdc("broadcast", 8'h04, 8'hfe);
      bus(1'b1, 8'h00, 8'hb0);
      far.send({2'b11, 8'hb0, 1'b0}, 10, 48);
      far.send({2'b11, 8'ha1, 1'b0}, 10, 48);
      wait_hi(1'b1, 400);
      rdc("mode1 filter", 8'h04, 8'ha1);
      bus(1'b1, 8'h00, 8'hc8);
      bus(1'b1, 8'h04, 8'h3c);
      far.grab(11, 48, fr);
      cmp("mode3 frame", {2'b11, 8'h3c, 1'b0}, fr);
      wait_hi(1'b1, 800);
      rdc("mode3 done", 8'h00, 8'hca);
      sync_en <= 1'b1;
      bus(1'b1, 8'h00, 8'h20);
      bus(1'b1, 8'h04, 8'h96);
      wait_hi(1'b1, 400);
      cmp("shift out", 11'h096, {3'h0, cap});
      rdc("shift done", 8'h00, 8'h22);
      rises = 0;
      bus(1'b1, 8'h00, 8'h10);
      // The event output lags the cleared flag, so let it fall first
      repeat (2) @(posedge i_ref_clk);
      wait_hi(1'b1, 800);
      repeat (60) @(posedge i_ref_clk);
      cmp("shift halted", 11'h0c3, {3'h0, cap});
      cmp("shift clocks", 11'h008, rises[10:0]);
      rdc("shift in", 8'h04, 8'hc3);
      test_done();
   end
endmodule
